// file: core/dpmpm_pkg.sv
// Package with constants and carrier types for the dual port MII mapper
package dpmpm_pkg;

    // Receive destination encodings
    localparam logic [1:0] RX_OWN = 2'h0;
    localparam logic [1:0] RX_OPP = 2'h1;
    localparam logic [1:0] RX_BOTH = 2'h2;
    localparam logic [1:0] RX_OFF = 2'h3;

    // Transmit source encodings
    localparam logic [1:0] TX_OWN = 2'h0;
    localparam logic [1:0] TX_OPP = 2'h1;
    localparam logic [1:0] TX_LOOP = 2'h2;
    localparam logic [1:0] TX_OFF = 2'h3;

    // Mapping field reset and extender values
    localparam logic [3:0] MAP_NORMAL = 4'h0;
    localparam logic [3:0] MAP_EXTENDER = 4'he;

    // Mapping field positions inside the 4-bit field
    localparam int RX_LSB = 2;
    localparam int TX_LSB = 0;

    // Nibble width of the media interface
    localparam int NIB_W = 4;

    // One direction of nibble traffic
    typedef struct packed {
        logic en;
        logic er;
        logic [3:0] d;
    } dpmpm_nib_s;

    // Per channel mapping field
    typedef struct packed {
        logic [1:0] rx;
        logic [1:0] tx;
    } dpmpm_map_s;

endpackage : dpmpm_pkg

// file: core/dpmpm_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module dpmpm_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // Both stages in one state word
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dpmpm_sy_s;
    dpmpm_sy_s st_q;
    dpmpm_sy_s st_d;

    // First stage feeds only the second
    always_comb
    begin
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    // Register both stages
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign dout = st_q.s2;
endmodule : dpmpm_sync

// file: core/dpmpm_xbar.sv
// Combinational nibble crossbar for one direction pair
`timescale 1ns/1ps
module dpmpm_xbar (
    input dpmpm_pkg::dpmpm_map_s map_a,
    input dpmpm_pkg::dpmpm_map_s map_b,
    input dpmpm_pkg::dpmpm_nib_s mac_tx_a,
    input dpmpm_pkg::dpmpm_nib_s mac_tx_b,
    input dpmpm_pkg::dpmpm_nib_s ch_rx_a,
    input dpmpm_pkg::dpmpm_nib_s ch_rx_b,
    output dpmpm_pkg::dpmpm_nib_s ch_tx_a,
    output dpmpm_pkg::dpmpm_nib_s ch_tx_b,
    output dpmpm_pkg::dpmpm_nib_s port_rx_a,
    output dpmpm_pkg::dpmpm_nib_s port_rx_b,
    output logic [1:0] port_src_a,
    output logic [1:0] port_src_b
);
    // Transmit source per channel
    always_comb
    begin
        case (map_a.tx)
            dpmpm_pkg::TX_OWN: ch_tx_a = mac_tx_a;
            dpmpm_pkg::TX_OPP: ch_tx_a = mac_tx_b; // Broadcast pairs fall out here
            dpmpm_pkg::TX_LOOP: ch_tx_a = ch_rx_b; // Extender loop
            default: ch_tx_a = '0;
        endcase
        case (map_b.tx)
            dpmpm_pkg::TX_OWN: ch_tx_b = mac_tx_b;
            dpmpm_pkg::TX_OPP: ch_tx_b = mac_tx_a;
            dpmpm_pkg::TX_LOOP: ch_tx_b = ch_rx_a;
            default: ch_tx_b = '0;
        endcase
    end

    // Port ownership per {rx A, rx B}: 01=channel A, 10=channel B, 00=off
    always_comb
    begin
        port_src_a = 2'h0;
        port_src_b = 2'h0;
        case ({map_a.rx, map_b.rx})
            // Owners keep their ports; a refused request falls back home
            4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'ha:
            begin
                port_src_a = 2'h1;
                port_src_b = 2'h2;
            end
            4'h3:
                port_src_a = 2'h1; // Channel B off, port B dark
            4'h5, 4'h6, 4'h9:
            begin
                port_src_a = 2'h2; // Swap, or both owners ceded
                port_src_b = 2'h1;
            end
            4'h7:
                port_src_b = 2'h1; // Channel A on port B only
            4'hb:
            begin
                port_src_a = 2'h1; // Mirror channel A
                port_src_b = 2'h1;
            end
            4'hc:
                port_src_b = 2'h2; // Channel A off, port A dark
            4'hd:
                port_src_a = 2'h2; // Channel B on port A only
            4'he:
            begin
                port_src_a = 2'h2; // Mirror channel B
                port_src_b = 2'h2;
            end
            default:
            begin
                port_src_a = 2'h0; // Both off, also the extender case
                port_src_b = 2'h0;
            end
        endcase
        port_rx_a = (port_src_a == 2'h1) ? ch_rx_a :
                    (port_src_a == 2'h2) ? ch_rx_b : '0;
        port_rx_b = (port_src_b == 2'h2) ? ch_rx_b :
                    (port_src_b == 2'h1) ? ch_rx_a : '0;
    end
endmodule : dpmpm_xbar

// file: core/dpmpm_top.sv
// Dual port MII mapper: mapping registers, strap capture, crossing, outputs
`timescale 1ns/1ps
module dpmpm_top (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_link,
    input wire logic link_resetn,
    // Software mapping writes, same domain as clk_sys
    input wire logic map_wr_a,
    input wire logic map_wr_b,
    input wire logic [3:0] map_wdata,
    // Straps, asynchronous pins
    input wire logic extender_strap,
    input wire logic reduced_mii_strap,
    // Per channel status from the channels, link domain
    input wire logic [1:0] ch_link,
    input wire logic [1:0] ch_isolate,
    input wire logic [1:0] ch_oe,
    input wire logic [1:0] ch_col,
    input wire logic [1:0] ch_crs_tx,
    input wire logic [1:0] ch_crs_rx,
    input wire logic [1:0] reduced_mii_en,
    // Data paths and status on the link clock; mapping and single clock outputs on clk_sys
    input dpmpm_pkg::dpmpm_nib_s mac_tx_a,
    input dpmpm_pkg::dpmpm_nib_s mac_tx_b,
    input dpmpm_pkg::dpmpm_nib_s ch_rx_a,
    input dpmpm_pkg::dpmpm_nib_s ch_rx_b,
    output dpmpm_pkg::dpmpm_nib_s ch_tx_a,
    output dpmpm_pkg::dpmpm_nib_s ch_tx_b,
    output dpmpm_pkg::dpmpm_nib_s port_rx_a,
    output dpmpm_pkg::dpmpm_nib_s port_rx_b,
    output logic [1:0] port_crs,
    output logic [1:0] port_oe,
    output logic [1:0] ch_jam,
    output logic [1:0] link_led,
    output logic [3:0] map_a_q_o,
    output logic [3:0] map_b_q_o,
    output logic single_clock_rx_enable,
    output logic single_clock_tx_enable
);
    // System domain state
    typedef struct packed {
        logic [3:0] map_a;
        logic [3:0] map_b;
        logic strap_done;
        logic scrx;
        logic sctx;
    } dpmpm_sys_s;

    // Link domain state
    typedef struct packed {
        dpmpm_pkg::dpmpm_nib_s tx_a;
        dpmpm_pkg::dpmpm_nib_s tx_b;
        dpmpm_pkg::dpmpm_nib_s rx_a;
        dpmpm_pkg::dpmpm_nib_s rx_b;
        logic [1:0] crs;
        logic [1:0] oe;
        logic [1:0] jam;
        logic [1:0] led;
    } dpmpm_lnk_s;

    dpmpm_sys_s s_q;
    dpmpm_sys_s s_d;
    dpmpm_lnk_s l_q;
    dpmpm_lnk_s l_d;
    logic [1:0] strap_s;
    logic [7:0] map_l;
    dpmpm_pkg::dpmpm_map_s ma;
    dpmpm_pkg::dpmpm_map_s mb;
    dpmpm_pkg::dpmpm_nib_s x_tx_a;
    dpmpm_pkg::dpmpm_nib_s x_tx_b;
    dpmpm_pkg::dpmpm_nib_s x_rx_a;
    dpmpm_pkg::dpmpm_nib_s x_rx_b;
    logic [1:0] src_a;
    logic [1:0] src_b;

    // Straps are pins: two flops first; kept out of reset so that the
    // pins are already settled on the capture edge right after reset
    dpmpm_sync #(.W(2)) u_strap (
        .clk_sys(clk_sys),
        .resetn(1'b1),
        .din({extender_strap, reduced_mii_strap}),
        .dout(strap_s)
    );

    // Mapping is quasi static; a level crossing of each bit is accepted
    // because software changes it only between frames
    dpmpm_sync #(.W(8)) u_map (
        .clk_sys(clk_link),
        .resetn(link_resetn),
        .din({s_q.map_a, s_q.map_b}),
        .dout(map_l)
    );

    assign ma = map_l[7:4];
    assign mb = map_l[3:0];

    // Mapping registers and strap capture after reset release
    always_comb
    begin
        s_d = s_q;
        if (!s_q.strap_done)
        begin
            // Capture once, synchronised strap
            // Speed, duplex and fiber setup stay with each channel's own straps
            s_d.strap_done = 1'b1;
            if (strap_s[1])
            begin
                s_d.map_a = dpmpm_pkg::MAP_EXTENDER;
                s_d.map_b = dpmpm_pkg::MAP_EXTENDER;
                s_d.scrx = !strap_s[0];
                s_d.sctx = !strap_s[0];
            end
        end
        else
        begin
            // Software writes only after capture
            if (map_wr_a)
                s_d.map_a = map_wdata;
            if (map_wr_b)
                s_d.map_b = map_wdata;
        end
    end

    // Register system state; normal mapping after reset
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            s_q.map_a <= dpmpm_pkg::MAP_NORMAL;
            s_q.map_b <= dpmpm_pkg::MAP_NORMAL;
            s_q.strap_done <= 1'b0;
            s_q.scrx <= 1'b0;
            s_q.sctx <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    // Routing crossbar on the link clock
    dpmpm_xbar u_xbar (
        .map_a(ma),
        .map_b(mb),
        .mac_tx_a(mac_tx_a),
        .mac_tx_b(mac_tx_b),
        .ch_rx_a(ch_rx_a),
        .ch_rx_b(ch_rx_b),
        .ch_tx_a(x_tx_a),
        .ch_tx_b(x_tx_b),
        .port_rx_a(x_rx_a),
        .port_rx_b(x_rx_b),
        .port_src_a(src_a),
        .port_src_b(src_b)
    );

    // Link side next state
    always_comb
    begin
        l_d = l_q;
        l_d.tx_a = x_tx_a;
        l_d.tx_b = x_tx_b;
        l_d.rx_a = x_rx_a;
        l_d.rx_b = x_rx_b;
        // Isolate of channel n blanks port n, whichever channel that port carries
        if (ch_isolate[0])
            l_d.rx_a = '0;
        if (ch_isolate[1])
            l_d.rx_b = '0;
        // Carrier sense: transmit route outside reduced mode
        l_d.crs[0] = reduced_mii_en[0] ?
            ((src_a == 2'h1) ? ch_crs_rx[0] : (src_a == 2'h2) ? ch_crs_rx[1] : 1'b0) :
            ((ma.tx == dpmpm_pkg::TX_OWN) ? ch_crs_tx[0] :
             (mb.tx == dpmpm_pkg::TX_OPP) ? ch_crs_tx[1] : 1'b0);
        l_d.crs[1] = reduced_mii_en[1] ?
            ((src_b == 2'h2) ? ch_crs_rx[1] : (src_b == 2'h1) ? ch_crs_rx[0] : 1'b0) :
            ((mb.tx == dpmpm_pkg::TX_OWN) ? ch_crs_tx[1] :
             (ma.tx == dpmpm_pkg::TX_OPP) ? ch_crs_tx[0] : 1'b0);
        // Enables untouched by mapping
        l_d.oe = ch_oe;
        // Link indicators stay per channel
        l_d.led = ch_link;
        // Shared source: any collision jams both
        if (ma.tx != mb.tx && ma.tx[1] == 1'b0 && mb.tx[1] == 1'b0 && (|ch_col))
            l_d.jam = 2'h3;
        else
            l_d.jam = ch_col;
    end

    // Register link state
    always_ff @(posedge clk_link)
    begin
        if (!link_resetn)
            l_q <= '0;
        else
            l_q <= l_d;
    end

    // Outputs straight from flops
    assign ch_tx_a = l_q.tx_a;
    assign ch_tx_b = l_q.tx_b;
    assign port_rx_a = l_q.rx_a;
    assign port_rx_b = l_q.rx_b;
    assign port_crs = l_q.crs;
    assign port_oe = l_q.oe;
    assign ch_jam = l_q.jam;
    assign link_led = l_q.led;
    assign map_a_q_o = s_q.map_a;
    assign map_b_q_o = s_q.map_b;
    assign single_clock_rx_enable = s_q.scrx;
    assign single_clock_tx_enable = s_q.sctx;

    // Strap seen on the capture edge; resetn in it keeps the release edge out
    sequence s_strap_seen;
        resetn && !s_q.strap_done && strap_s[1];
    endsequence

    // Both fields in the loop mapping
    sequence s_loop_set;
        s_q.map_a == dpmpm_pkg::MAP_EXTENDER && s_q.map_b == dpmpm_pkg::MAP_EXTENDER;
    endsequence

    // Reset gives normal mapping
    a_reset_normal: assert property (@(posedge clk_sys)
        $rose(resetn) |-> s_q.map_a == dpmpm_pkg::MAP_NORMAL)
        else $error("mapping not normal after reset");

    // Extender strap yields loop mapping
    a_strap_ext: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_strap_seen |=> s_loop_set)
        else $error("strap did not set extender mapping");

    // Single clock follows strap pair
    a_strap_sc: assert property (@(posedge clk_sys) disable iff (!resetn)
        (resetn && !s_q.strap_done && strap_s == 2'h2) |=> (s_q.scrx && s_q.sctx))
        else $error("single clock not enabled");

    // Reduced strap keeps single clock off
    a_sc_reduced: assert property (@(posedge clk_sys) disable iff (!resetn)
        (resetn && !s_q.strap_done && strap_s == 2'h3) |=> (!s_q.scrx && !s_q.sctx))
        else $error("single clock set with reduced strap");

    // Software write lands once the strap is captured
    a_write_map: assert property (@(posedge clk_sys) disable iff (!resetn)
        (resetn && s_q.strap_done && map_wr_a) |=> map_a_q_o == $past(map_wdata))
        else $error("mapping write lost");

    // Loop mapping crosses receive data
    a_loop_tx: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (ma.tx == dpmpm_pkg::TX_LOOP) |=> ch_tx_a == $past(ch_rx_b))
        else $error("loop transmit wrong");

    // Loop on channel B takes channel A receive data
    a_loop_b: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (link_resetn && mb.tx == dpmpm_pkg::TX_LOOP) |=> ch_tx_b == $past(ch_rx_a))
        else $error("loop transmit on channel B wrong");

    // Disabled transmit sends nothing
    a_tx_off: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (link_resetn && ma.tx == dpmpm_pkg::TX_OFF) |=> ch_tx_a == '0)
        else $error("disabled transmit not quiet");

    // Broadcast from port A feeds channel B too
    a_bcast_tx: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (link_resetn && ma.tx == dpmpm_pkg::TX_OWN && mb.tx == dpmpm_pkg::TX_OPP)
        |=> ch_tx_b == $past(mac_tx_a))
        else $error("broadcast transmit wrong");

    // Enables follow own channel
    a_oe_own: assert property (@(posedge clk_link) disable iff (!link_resetn)
        link_resetn |=> port_oe == $past(ch_oe))
        else $error("output enable remapped");

    // Indicators follow own channel
    a_led_own: assert property (@(posedge clk_link) disable iff (!link_resetn)
        link_resetn |=> link_led == $past(ch_link))
        else $error("indicator remapped");

    // Both receive off disables both ports
    a_rx_off: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (ma.rx == dpmpm_pkg::RX_OFF && mb.rx == dpmpm_pkg::RX_OFF)
        |=> (port_rx_a == '0 && port_rx_b == '0))
        else $error("port not disabled");

    // Extender mapping keeps both receive ports quiet
    a_ext_quiet: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (link_resetn && ma == dpmpm_pkg::MAP_EXTENDER && mb == dpmpm_pkg::MAP_EXTENDER)
        |=> (port_rx_a == '0 && port_rx_b == '0))
        else $error("receive output in extender mapping");

    // Normal mapping: port A shows channel A
    a_normal_own: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (link_resetn && ma == dpmpm_pkg::MAP_NORMAL && mb == dpmpm_pkg::MAP_NORMAL
        && ch_isolate == 2'h0) |=> port_rx_a == $past(ch_rx_a))
        else $error("normal receive route wrong");

    // Full swap: port A shows channel B
    a_swap_rx: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (link_resetn && ma.rx == dpmpm_pkg::RX_OPP && mb.rx == dpmpm_pkg::RX_OPP
        && ch_isolate == 2'h0) |=> port_rx_a == $past(ch_rx_b))
        else $error("swapped receive route wrong");

    // Mirror of channel A on both ports
    a_rx_mirror: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (link_resetn && ma.rx == dpmpm_pkg::RX_BOTH && mb.rx == dpmpm_pkg::RX_OFF
        && ch_isolate == 2'h0) |=> (port_rx_a == $past(ch_rx_a) && port_rx_b == $past(ch_rx_a)))
        else $error("mirror route wrong");

    // Isolate of channel A blanks port A whatever the mapping
    a_isolate_own: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (link_resetn && ch_isolate[0]) |=> port_rx_a == '0)
        else $error("isolate not applied");

    // Carrier sense from the transmitter outside reduced mode
    a_crs_tx: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (link_resetn && !reduced_mii_en[0] && ma.tx == dpmpm_pkg::TX_OWN)
        |=> port_crs[0] == $past(ch_crs_tx[0]))
        else $error("transmit carrier sense wrong");

    // Carrier sense from the receiver in reduced mode
    a_crs_rx: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (link_resetn && reduced_mii_en[1] && mb.rx == dpmpm_pkg::RX_OWN)
        |=> port_crs[1] == $past(ch_crs_rx[1]))
        else $error("receive carrier sense wrong");

    // Broadcast collision jams both
    a_jam_both: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (ma.tx == dpmpm_pkg::TX_OWN && mb.tx == dpmpm_pkg::TX_OPP && ch_col[1])
        |=> ch_jam == 2'h3)
        else $error("jam not shared");

    // Without a shared source each collision stays with its channel
    a_jam_plain: assert property (@(posedge clk_link) disable iff (!link_resetn)
        (link_resetn && ma.tx == mb.tx) |=> ch_jam == $past(ch_col))
        else $error("jam spread without shared source");
endmodule : dpmpm_top

// file: verification/dpmpm_mac_model.sv
// Stand-in for the MAC or channel that streams nibbles into one mapper input
`timescale 1ns/1ps
module dpmpm_mac_model #(
    parameter logic [3:0] STEP = 4'h1
) (
    input wire logic clk_link,
    input wire logic link_resetn,
    input wire logic go,
    output dpmpm_pkg::dpmpm_nib_s nib = '0
);
    // One nibble every link cycle, full duplex, no carrier wait
    // Nibble wide at one rate on the shared link clock: rx and tx both single
    // clocked, never the serial ten meg mode
    always @(posedge clk_link)
    begin
        if (!link_resetn)
        begin
            nib <= '0;
        end
        else if (go)
        begin
            // Data steps each cycle so a wrong route shows at once
            nib <= '{en: 1'b1, er: nib.d[3], d: nib.d + STEP};
        end
        else
        begin
            // Idle: inverse of the last value, never a stale copy
            nib <= '{en: 1'b0, er: 1'b0, d: ~nib.d};
        end
    end
endmodule : dpmpm_mac_model

// file: verification/testbench.sv
// Self-checking bench for the dual port media interface mapper
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic resetn = 1'b0;
    logic link_resetn = 1'b0;
    logic map_wr_a = 1'b0;
    logic map_wr_b = 1'b0;
    logic [3:0] map_wdata = 4'h0;
    logic extender_strap = 1'b0;
    logic reduced_mii_strap = 1'b0;
    logic [1:0] ch_link = 2'h0, ch_isolate = 2'h0, ch_oe = 2'h0, ch_col = 2'h0;
    logic [1:0] ch_crs_tx = 2'h0, ch_crs_rx = 2'h0, reduced_mii_en = 2'h0;
    logic go = 1'b0;
    dpmpm_pkg::dpmpm_nib_s mac_tx_a, mac_tx_b, ch_rx_a, ch_rx_b;
    dpmpm_pkg::dpmpm_nib_s ch_tx_a, ch_tx_b, port_rx_a, port_rx_b;
    logic [1:0] port_crs, port_oe, ch_jam, link_led;
    logic [3:0] map_a_q_o, map_b_q_o;
    logic single_clock_rx_enable, single_clock_tx_enable;
    int n_mismatch = 0;
    int cmp_count = 0;
    // Source index per transmit code: 0/1 MAC A/B, 2/3 channel rx A/B, 4 blank
    int tx_sel_a[4] = '{0, 1, 3, 4};
    int tx_sel_b[4] = '{1, 0, 2, 4};
    // Port source per {rx code A, rx code B}, same indices
    int rx_sel_a[16] = '{2, 2, 2, 2, 2, 3, 3, 4, 2, 3, 2, 2, 4, 3, 3, 4};
    int rx_sel_b[16] = '{3, 3, 3, 4, 3, 2, 2, 2, 3, 2, 3, 2, 3, 4, 3, 4};

    // System clock
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end
    // Link clock, phase unrelated to the system clock
    initial
    begin
        #3.7;
        forever #15 clk_link = ~clk_link;
    end

    dpmpm_top dpmpm_top_i (.clk_sys(clk_sys), .resetn(resetn), .clk_link(clk_link),
        .link_resetn(link_resetn), .map_wr_a(map_wr_a), .map_wr_b(map_wr_b),
        .map_wdata(map_wdata), .extender_strap(extender_strap),
        .reduced_mii_strap(reduced_mii_strap), .ch_link(ch_link), .ch_isolate(ch_isolate),
        .ch_oe(ch_oe), .ch_col(ch_col), .ch_crs_tx(ch_crs_tx), .ch_crs_rx(ch_crs_rx),
        .reduced_mii_en(reduced_mii_en), .mac_tx_a(mac_tx_a), .mac_tx_b(mac_tx_b),
        .ch_rx_a(ch_rx_a), .ch_rx_b(ch_rx_b), .ch_tx_a(ch_tx_a), .ch_tx_b(ch_tx_b),
        .port_rx_a(port_rx_a), .port_rx_b(port_rx_b), .port_crs(port_crs),
        .port_oe(port_oe), .ch_jam(ch_jam), .link_led(link_led), .map_a_q_o(map_a_q_o),
        .map_b_q_o(map_b_q_o), .single_clock_rx_enable(single_clock_rx_enable),
        .single_clock_tx_enable(single_clock_tx_enable));
    // Distinct steps keep the four streams apart
    dpmpm_mac_model #(.STEP(4'h1)) mac_a (.clk_link(clk_link), .link_resetn(link_resetn),
        .go(go), .nib(mac_tx_a));
    dpmpm_mac_model #(.STEP(4'h3)) mac_b (.clk_link(clk_link), .link_resetn(link_resetn),
        .go(go), .nib(mac_tx_b));
    dpmpm_mac_model #(.STEP(4'h5)) rx_a (.clk_link(clk_link), .link_resetn(link_resetn),
        .go(go), .nib(ch_rx_a));
    dpmpm_mac_model #(.STEP(4'h7)) rx_b (.clk_link(clk_link), .link_resetn(link_resetn),
        .go(go), .nib(ch_rx_b));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Verdict and end of run
    task automatic stop_test;
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // Reset both domains with given straps; a write in the capture cycle is dropped
    task automatic do_reset(input logic ext, input logic red, input logic [3:0] exp_map,
        input logic [1:0] exp_sc);
        @(posedge clk_link);
        link_resetn <= 1'b0;
        go <= 1'b0;
        @(posedge clk_sys);
        resetn <= 1'b0;
        extender_strap <= ext;
        reduced_mii_strap <= red;
        repeat (10) @(posedge clk_sys);
        @(posedge clk_link);
        link_resetn <= 1'b1;
        @(posedge clk_sys);
        resetn <= 1'b1;
        map_wr_a <= 1'b1;
        map_wdata <= 4'h5;
        @(posedge clk_sys);
        map_wr_a <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(map_a_q_o, exp_map);
        chk(map_b_q_o, exp_map);
        chk({single_clock_rx_enable, single_clock_tx_enable}, exp_sc);
        // Let the captured mapping cross to the link side before traffic
        repeat (3) @(posedge clk_link);
    endtask : do_reset

    // Write both fields between frames, then resume traffic once crossed
    task automatic set_maps(input logic [3:0] a, input logic [3:0] b);
        @(posedge clk_link);
        go <= 1'b0;
        @(posedge clk_sys);
        map_wr_a <= 1'b1;
        map_wdata <= a;
        @(posedge clk_sys);
        map_wr_a <= 1'b0;
        map_wr_b <= 1'b1;
        map_wdata <= b;
        @(posedge clk_sys);
        map_wr_b <= 1'b0;
        @(negedge clk_sys);
        chk(map_a_q_o, a);
        chk(map_b_q_o, b);
        repeat (6) @(posedge clk_link);
        go <= 1'b1;
    endtask : set_maps

    // Each data output (both channel transmits, both port receives) must carry last cycle's selected input
    task automatic check_paths(input logic [3:0] a, input logic [3:0] b);
        dpmpm_pkg::dpmpm_nib_s s[5];
        repeat (3)
        begin
            @(negedge clk_link);
            s = '{mac_tx_a, mac_tx_b, ch_rx_a, ch_rx_b, '0};
            @(negedge clk_link);
            chk(ch_tx_a, s[tx_sel_a[a[1:0]]]);
            chk(ch_tx_b, s[tx_sel_b[b[1:0]]]);
            chk(port_rx_a, s[rx_sel_a[{a[3:2], b[3:2]}]]);
            chk(port_rx_b, s[rx_sel_b[{a[3:2], b[3:2]}]]);
        end
    endtask : check_paths

    task automatic test_reset;
        do_reset(1'b0, 1'b0, dpmpm_pkg::MAP_NORMAL, 2'b00);
        @(posedge clk_link);
        go <= 1'b1;
        check_paths(4'h0, 4'h0);
        $display("test_reset done");
    endtask : test_reset

    // Every pair of mapping fields, normal, swap, loop, broadcast, mirror, off
    task automatic test_maps;
        for (int a = 0; a < 16; a++)
        begin
            for (int b = 0; b < 16; b++)
            begin
                set_maps(4'(a), 4'(b));
                check_paths(4'(a), 4'(b));
            end
        end
        $display("test_maps done");
    endtask : test_maps

    // Enables, indicators, carrier sense and jam under remapping
    // Power saving stays off in the channels while ports are remapped
    task automatic test_side;
        @(posedge clk_link);
        ch_oe <= 2'b01;
        ch_link <= 2'b10;
        ch_crs_tx <= 2'b01;
        ch_crs_rx <= 2'b10;
        set_maps(4'h5, 4'h5);
        repeat (3) @(negedge clk_link);
        chk(port_oe, 2'b01);
        chk(link_led, 2'b10);
        chk(port_crs, 2'b10);
        @(posedge clk_link);
        reduced_mii_en <= 2'b11; // Both channels switched together
        repeat (3) @(negedge clk_link);
        chk(port_crs, 2'b01);
        @(posedge clk_link);
        ch_isolate <= 2'b01; // Isolate of channel A, port A carries channel B
        repeat (3) @(negedge clk_link);
        chk(port_rx_a, 32'h0);
        @(posedge clk_link);
        ch_isolate <= 2'b00;
        reduced_mii_en <= 2'b00;
        ch_col <= 2'b01;
        set_maps(4'h0, 4'h1);
        repeat (3) @(negedge clk_link);
        chk(ch_jam, 2'b11);
        set_maps(4'h0, 4'h0);
        repeat (3) @(negedge clk_link);
        chk(ch_jam, 2'b01);
        @(posedge clk_link);
        ch_col <= 2'b00;
        $display("test_side done");
    endtask : test_side

    // Extender strap with and without the reduced strap
    task automatic test_strap;
        do_reset(1'b1, 1'b0, dpmpm_pkg::MAP_EXTENDER, 2'b11);
        @(posedge clk_link);
        go <= 1'b1;
        check_paths(4'he, 4'he);
        do_reset(1'b1, 1'b1, dpmpm_pkg::MAP_EXTENDER, 2'b00);
        do_reset(1'b0, 1'b0, dpmpm_pkg::MAP_NORMAL, 2'b00);
        $display("test_strap done");
    endtask : test_strap

    // Main sequence
    initial
    begin
        test_reset();
        test_maps();
        test_side();
        test_strap();
        stop_test();
    end
    // Watchdog, well beyond the expected run of about 95 us
    initial
    begin
        #400000;
        n_mismatch++;
        stop_test();
    end
endmodule : testbench
